/* File: core/dwt_pkg.sv */
// Shared constants and types for the dual watchdog block
package dwt_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned CNT_W = 14;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] RELOAD_RST = 14'h3fff;
   localparam logic [CNT_W-1:0] WIN_HI_RST = 14'h3fff;
   localparam logic [CNT_W-1:0] WIN_LO_RST = 14'h0000;

   // ----------------------------------------------------------------
   // Fault response
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ACT_RESET = 2'b00,
      ACT_NMI   = 2'b01,
      ACT_IRQ   = 2'b10
   } dwt_action_e;

   localparam dwt_action_e ACTION_RST = ACT_RESET;

   // Counter state
   typedef enum logic [0:0] {
      ST_STOP = 1'b0,
      ST_RUN  = 1'b1
   } dwt_state_e;

   // Configuration written once by software
   typedef struct packed {
      dwt_action_e      action;
      logic [CNT_W-1:0] reload;
      logic [CNT_W-1:0] win_hi;
      logic [CNT_W-1:0] win_lo;
   } dwt_cfg_s;

   localparam dwt_cfg_s CFG_RST = '{
      action: ACTION_RST,
      reload: RELOAD_RST,
      win_hi: WIN_HI_RST,
      win_lo: WIN_LO_RST
   };

   // Fault indications to reset and interrupt controllers
   typedef struct packed {
      logic reset_req;
      logic nmi;
      logic irq;
   } dwt_fault_s;

endpackage : dwt_pkg

/* File: core/dwt_counter.sv */
// One watchdog down-counter with refresh window and fault detection
`timescale 1ns/1ns
module dwt_counter #(
   parameter int unsigned W = 14
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_sync_n,
   // Count control
   input  wire logic         tick,
   input  wire logic         start,
   input  wire logic         refresh,
   input  wire logic         auto_restart,
   input  wire logic [W-1:0] reload,
   input  wire logic [W-1:0] win_hi,
   input  wire logic [W-1:0] win_lo,
   // Results
   output logic [W-1:0]      count_q,
   output logic              running_q,
   output logic              underflow_q,
   output logic              refresh_err_q
);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   dwt_pkg::dwt_state_e state_q;
   dwt_pkg::dwt_state_e state_d;
   logic [W-1:0]        count_d;
   logic                underflow_d;
   logic                refresh_err_d;
   logic                in_window;

   assign in_window = (count_q >= win_lo) && (count_q <= win_hi);

   always_comb begin
      state_d       = state_q;
      count_d       = count_q;
      underflow_d   = 1'b0;
      refresh_err_d = 1'b0;
      case (state_q)
         dwt_pkg::ST_STOP: begin
            // A refresh also starts a stopped counter
            if (start || refresh) begin
               state_d = dwt_pkg::ST_RUN;
               count_d = reload;
            end
         end
         dwt_pkg::ST_RUN: begin
            // Refresh takes priority over a tick in the same cycle
            if (refresh) begin
               if (in_window) begin
                  count_d = reload;
               end else begin
                  refresh_err_d = 1'b1;
               end
            end else if (tick) begin
               if (count_q == '0) begin
                  underflow_d = 1'b1;
               end else begin
                  count_d = count_q - 1'b1;
               end
            end
            if (underflow_d || refresh_err_d) begin
               count_d = reload;
               if (!auto_restart) begin
                  state_d = dwt_pkg::ST_STOP;
               end
            end
         end
         default: begin
            state_d = dwt_pkg::ST_STOP;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q       <= dwt_pkg::ST_STOP;
         count_q       <= dwt_pkg::RELOAD_RST;
         underflow_q   <= 1'b0;
         refresh_err_q <= 1'b0;
      end else begin
         state_q       <= state_d;
         count_q       <= count_d;
         underflow_q   <= underflow_d;
         refresh_err_q <= refresh_err_d;
      end
   end

   assign running_q = (state_q == dwt_pkg::ST_RUN);

endmodule : dwt_counter

/* File: core/dwt_top.sv */
// Top of the dual watchdog: windowed and independent counters
// What this block does
// - Windowed counter is 14-bit, decrements, reloads on refresh
// - Windowed underflow can request full device reset
// - Windowed underflow can raise NMI or interrupt instead
// - Refresh outside permitted window counts as fault
// - Independent counter is 14-bit, needs periodic refresh
// - Independent counter ticks from its own oscillator
// - Independent underflow gives reset, NMI or interrupt
// - Independent counter starts on refresh; on reset and after a fault only if strapped
// - Independent refresh error handled like underflow
`timescale 1ns/1ns
module dwt_top #(
   parameter int unsigned CNT_W = dwt_pkg::CNT_W
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Windowed watchdog software side
   input  wire logic              wwd_cfg_write,
   input  wire dwt_pkg::dwt_cfg_s wwd_cfg,
   input  wire logic              wwd_refresh,
   // Independent watchdog software side
   input  wire logic              iwd_cfg_write,
   input  wire dwt_pkg::dwt_cfg_s iwd_cfg,
   input  wire logic              iwd_refresh,
   input  wire logic              iwd_auto_strap,
   // Independent watchdog oscillator, sampled in the clk domain
   input  wire logic              iwd_osc,
   // Fault outputs to reset and interrupt controllers
   output dwt_pkg::dwt_fault_s    wwd_fault_q,
   output dwt_pkg::dwt_fault_s    iwd_fault_q,
   // Status
   output logic [CNT_W-1:0]       wwd_count_q,
   output logic [CNT_W-1:0]       iwd_count_q,
   output logic                   wwd_running_q,
   output logic                   iwd_running_q,
   output logic                   wwd_refresh_err_q,
   output logic                   iwd_refresh_err_q
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Configuration capture, one write only
   // ----------------------------------------------------------------
   dwt_pkg::dwt_cfg_s wwd_cfg_q;
   dwt_pkg::dwt_cfg_s wwd_cfg_d;
   dwt_pkg::dwt_cfg_s iwd_cfg_q;
   dwt_pkg::dwt_cfg_s iwd_cfg_d;
   logic              wwd_lock_q;
   logic              wwd_lock_d;
   logic              iwd_lock_q;
   logic              iwd_lock_d;
   logic              wwd_start_q;
   logic              wwd_start_d;
   logic              strap_done_q;
   logic              strap_done_d;
   logic              iwd_auto_q;
   logic              iwd_auto_d;
   logic              iwd_start_q;
   logic              iwd_start_d;

   always_comb begin
      wwd_cfg_d    = wwd_cfg_q;
      wwd_lock_d   = wwd_lock_q;
      wwd_start_d  = 1'b0;
      iwd_cfg_d    = iwd_cfg_q;
      iwd_lock_d   = iwd_lock_q;
      strap_done_d = 1'b1;
      iwd_auto_d   = iwd_auto_q;
      iwd_start_d  = 1'b0;
      // Later writes are ignored so a runaway program cannot disarm it
      if (wwd_cfg_write && !wwd_lock_q) begin
         wwd_cfg_d   = wwd_cfg;
         wwd_lock_d  = 1'b1;
         wwd_start_d = 1'b1;
      end
      if (iwd_cfg_write && !iwd_lock_q) begin
         iwd_cfg_d  = iwd_cfg;
         iwd_lock_d = 1'b1;
      end
      // Strap caught once, in the first cycle after reset release
      if (!strap_done_q) begin
         iwd_auto_d  = iwd_auto_strap;
         iwd_start_d = iwd_auto_strap;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         wwd_cfg_q    <= dwt_pkg::CFG_RST;
         wwd_lock_q   <= 1'b0;
         wwd_start_q  <= 1'b0;
         iwd_cfg_q    <= dwt_pkg::CFG_RST;
         iwd_lock_q   <= 1'b0;
         strap_done_q <= 1'b0;
         iwd_auto_q   <= 1'b0;
         iwd_start_q  <= 1'b0;
      end else begin
         wwd_cfg_q    <= wwd_cfg_d;
         wwd_lock_q   <= wwd_lock_d;
         wwd_start_q  <= wwd_start_d;
         iwd_cfg_q    <= iwd_cfg_d;
         iwd_lock_q   <= iwd_lock_d;
         strap_done_q <= strap_done_d;
         iwd_auto_q   <= iwd_auto_d;
         iwd_start_q  <= iwd_start_d;
      end
   end

   // ----------------------------------------------------------------
   // Independent oscillator edge detect
   // ----------------------------------------------------------------
   logic osc_prev_q;
   logic osc_prev_d;
   logic iwd_tick;

   always_comb begin
      osc_prev_d = iwd_osc;
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_prev_d;
      end
   end

   // Only oscillator edges advance it, never clk alone
   assign iwd_tick = iwd_osc && !osc_prev_q;

   // ----------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] wwd_cnt;
   logic [CNT_W-1:0] iwd_cnt;
   logic             wwd_run;
   logic             iwd_run;
   logic             wwd_uf;
   logic             iwd_uf;
   logic             wwd_rerr;
   logic             iwd_rerr;

   // Peripheral clock ticks every cycle
   dwt_counter #(
      .W            (CNT_W)
   ) u_wwd (
      .clk          (clk),
      .rst_sync_n   (rst_sync_q),
      .tick         (wwd_lock_q),
      .start        (wwd_start_q),
      .refresh      (wwd_refresh && wwd_lock_q),
      .auto_restart (1'b1),
      .reload       (wwd_cfg_q.reload),
      .win_hi       (wwd_cfg_q.win_hi),
      .win_lo       (wwd_cfg_q.win_lo),
      .count_q      (wwd_cnt),
      .running_q    (wwd_run),
      .underflow_q  (wwd_uf),
      .refresh_err_q(wwd_rerr)
   );

   // Restarts after a fault only when autostart was strapped
   dwt_counter #(
      .W            (CNT_W)
   ) u_iwd (
      .clk          (clk),
      .rst_sync_n   (rst_sync_q),
      .tick         (iwd_tick),
      .start        (iwd_start_q),
      .refresh      (iwd_refresh),
      .auto_restart (iwd_auto_q),
      .reload       (iwd_cfg_q.reload),
      .win_hi       (iwd_cfg_q.win_hi),
      .win_lo       (iwd_cfg_q.win_lo),
      .count_q      (iwd_cnt),
      .running_q    (iwd_run),
      .underflow_q  (iwd_uf),
      .refresh_err_q(iwd_rerr)
   );

   // ----------------------------------------------------------------
   // Fault routing and status
   // ----------------------------------------------------------------
   function automatic dwt_pkg::dwt_fault_s route(input logic fault,
                                                 input dwt_pkg::dwt_action_e act);
      dwt_pkg::dwt_fault_s f;
      f           = '0;
      f.reset_req = fault && (act == dwt_pkg::ACT_RESET);
      f.nmi       = fault && (act == dwt_pkg::ACT_NMI);
      f.irq       = fault && (act == dwt_pkg::ACT_IRQ);
      return f;
   endfunction : route

   dwt_pkg::dwt_fault_s wwd_fault_d;
   dwt_pkg::dwt_fault_s iwd_fault_d;
   logic                wwd_rerr_d;
   logic                iwd_rerr_d;
   logic                wwd_good_ref;
   logic                iwd_good_ref;
   logic                wwd_ref_q;
   logic                iwd_ref_q;

   // A refresh that did not raise an error one cycle later was valid
   assign wwd_good_ref = wwd_ref_q && !wwd_rerr;
   assign iwd_good_ref = iwd_ref_q && !iwd_rerr;

   always_comb begin
      wwd_fault_d = route(wwd_uf || wwd_rerr, wwd_cfg_q.action);
      iwd_fault_d = route(iwd_uf || iwd_rerr, iwd_cfg_q.action);
      // Set wins over clear when both land together
      wwd_rerr_d  = wwd_rerr || (wwd_refresh_err_q && !wwd_good_ref);
      iwd_rerr_d  = iwd_rerr || (iwd_refresh_err_q && !iwd_good_ref);
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         wwd_fault_q       <= '0;
         iwd_fault_q       <= '0;
         wwd_refresh_err_q <= 1'b0;
         iwd_refresh_err_q <= 1'b0;
         wwd_count_q       <= dwt_pkg::RELOAD_RST;
         iwd_count_q       <= dwt_pkg::RELOAD_RST;
         wwd_running_q     <= 1'b0;
         iwd_running_q     <= 1'b0;
         wwd_ref_q         <= 1'b0;
         iwd_ref_q         <= 1'b0;
      end else begin
         wwd_fault_q       <= wwd_fault_d;
         iwd_fault_q       <= iwd_fault_d;
         wwd_refresh_err_q <= wwd_rerr_d;
         iwd_refresh_err_q <= iwd_rerr_d;
         wwd_count_q       <= wwd_cnt;
         iwd_count_q       <= iwd_cnt;
         wwd_running_q     <= wwd_run;
         iwd_running_q     <= iwd_run;
         wwd_ref_q         <= wwd_refresh && wwd_run;
         iwd_ref_q         <= iwd_refresh && iwd_run;
      end
   end

endmodule : dwt_top

/* File: dv/dwt_chk.sv */
// Assertion checker for the dual watchdog top
`timescale 1ns/1ns
module dwt_chk (
   // Clock and reset
   input wire logic                clk,
   input wire logic                rst_n,
   // Software side
   input wire logic                wwd_refresh,
   input wire logic                iwd_refresh,
   input wire logic                iwd_cfg_write,
   input wire logic                iwd_osc,
   // Watched outputs
   input wire dwt_pkg::dwt_fault_s wwd_fault_q,
   input wire dwt_pkg::dwt_fault_s iwd_fault_q,
   input wire logic [13:0]         wwd_count_q,
   input wire logic [13:0]         iwd_count_q,
   input wire logic                wwd_running_q,
   input wire logic                iwd_running_q,
   input wire logic                wwd_refresh_err_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   // Long enough to cover the oscillator sampling path
   sequence s_osc_quiet;
      (!iwd_refresh && !iwd_cfg_write && $stable(iwd_osc))[*8];
   endsequence
   sequence s_err_set;
      $rose(wwd_refresh_err_q);
   endsequence
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   AST_WWD_PULSE: assert property (wwd_fault_q != 3'h0 |=> wwd_fault_q == 3'h0)
      else $error("windowed fault wider than one cycle");
   AST_WWD_ONE: assert property ($onehot0(wwd_fault_q))
      else $error("windowed fault has several kinds");
   AST_IWD_ONE: assert property ($onehot0(iwd_fault_q))
      else $error("independent fault has several kinds");
   AST_IWD_PULSE: assert property (iwd_fault_q != 3'h0 |=> iwd_fault_q == 3'h0)
      else $error("independent fault wider than one cycle");
   AST_ERR_CLEAR: assert property ($fell(wwd_refresh_err_q) |->
      ($past(wwd_refresh) || $past(wwd_refresh, 2) || $past(wwd_refresh, 3)))
      else $error("refresh error cleared without refresh");
   AST_ERR_FAULT: assert property (s_err_set |-> ##[0:3] wwd_fault_q != 3'h0)
      else $error("refresh error gave no fault");
   AST_WWD_DEC: assert property ($rose(wwd_running_q) |=>
      wwd_count_q == $past(wwd_count_q) - 14'h0001)
      else $error("windowed count did not decrement");
   AST_IWD_HOLD: assert property (s_osc_quiet |-> $stable(iwd_count_q))
      else $error("independent count moved without oscillator");
   AST_IWD_START: assert property (iwd_refresh |-> ##[1:4] iwd_running_q)
      else $error("independent refresh did not start counter");
endmodule : dwt_chk

bind dwt_top dwt_chk u_dwt_chk (.clk, .rst_n, .wwd_refresh, .iwd_refresh, .iwd_cfg_write,
   .iwd_osc, .wwd_fault_q, .iwd_fault_q, .wwd_count_q, .iwd_count_q, .wwd_running_q,
   .iwd_running_q, .wwd_refresh_err_q);

/* File: dv/dwt_sys_model.sv */
// Reset and interrupt controller model tallying fault requests
`timescale 1ns/1ns
module dwt_sys_model (
   // Clock
   input wire logic                clk,
   // Fault requests
   input wire dwt_pkg::dwt_fault_s wwd_fault,
   input wire dwt_pkg::dwt_fault_s iwd_fault,
   // Tallies
   output int unsigned             n_rst,
   output int unsigned             n_nmi,
   output int unsigned             n_irq
);
   int unsigned rst_cnt = 0;
   int unsigned nmi_cnt = 0;
   int unsigned irq_cnt = 0;
   assign n_rst = rst_cnt;
   assign n_nmi = nmi_cnt;
   assign n_irq = irq_cnt;
   always @(posedge clk) begin
      if (wwd_fault.reset_req || iwd_fault.reset_req) rst_cnt <= rst_cnt + 1;
      if (wwd_fault.nmi || iwd_fault.nmi) nmi_cnt <= nmi_cnt + 1;
      if (wwd_fault.irq || iwd_fault.irq) irq_cnt <= irq_cnt + 1;
   end
endmodule : dwt_sys_model

/* File: dv/dwt_top_tb.sv */
// Self-checking testbench for the dual watchdog top
`timescale 1ns/1ns
module dwt_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, wwd_cfg_write = 1'b0, wwd_refresh = 1'b0, osc_en = 1'b0;
   logic iwd_cfg_write = 1'b0, iwd_refresh = 1'b0, iwd_auto_strap = 1'b0, iwd_osc = 1'b0;
   dwt_pkg::dwt_cfg_s   wwd_cfg = dwt_pkg::CFG_RST, iwd_cfg = dwt_pkg::CFG_RST;
   dwt_pkg::dwt_fault_s wwd_fault_q, iwd_fault_q;
   logic [13:0]         wwd_count_q, iwd_count_q;
   logic                wwd_running_q, iwd_running_q, wwd_refresh_err_q, iwd_refresh_err_q;
   int unsigned         n_rst, n_nmi, n_irq, mismatches = 0, num_checks = 0;

   dwt_top u_dwt_top (.clk, .rst_n, .wwd_cfg_write, .wwd_cfg, .wwd_refresh, .iwd_cfg_write,
      .iwd_cfg, .iwd_refresh, .iwd_auto_strap, .iwd_osc, .wwd_fault_q, .iwd_fault_q,
      .wwd_count_q, .iwd_count_q, .wwd_running_q, .iwd_running_q, .wwd_refresh_err_q,
      .iwd_refresh_err_q);
   dwt_sys_model u_dwt_sys_model (.clk, .wwd_fault(wwd_fault_q), .iwd_fault(iwd_fault_q),
      .n_rst, .n_nmi, .n_irq);

   always #50 clk = ~clk;
   // Oscillator rises every second clock, slow enough to be sampled
   always @(posedge clk) begin
      #1 if (osc_en) iwd_osc <= ~iwd_osc;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk_b(input string nm, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s exp %b got %b", nm, exp, got);
      end
   endtask : chk_b
   task automatic chk_f(input string nm, input dwt_pkg::dwt_fault_s exp,
                        input dwt_pkg::dwt_fault_s got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s exp %b got %b", nm, exp, got);
      end
   endtask : chk_f
   task automatic do_reset(input logic strap);
      rst_n = 1'b0;
      osc_en = 1'b0;
      iwd_auto_strap = strap;
      step(5);
      rst_n = 1'b1;
      step(3);
   endtask : do_reset
   task automatic cfg(input logic iwd, input dwt_pkg::dwt_action_e a, input logic [13:0] rl,
                      input logic [13:0] hi, input logic [13:0] lo);
      if (iwd) begin
         iwd_cfg = '{a, rl, hi, lo};
         iwd_cfg_write = 1'b1;
      end else begin
         wwd_cfg = '{a, rl, hi, lo};
         wwd_cfg_write = 1'b1;
      end
      step(1);
      iwd_cfg_write = 1'b0;
      wwd_cfg_write = 1'b0;
   endtask : cfg
   task automatic refresh(input logic iwd);
      if (iwd) iwd_refresh = 1'b1;
      else wwd_refresh = 1'b1;
      step(1);
      iwd_refresh = 1'b0;
      wwd_refresh = 1'b0;
   endtask : refresh
   task automatic wait_f(input logic iwd, output dwt_pkg::dwt_fault_s f);
      f = 3'h0;
      for (int i = 0; i < 300 && f == 3'h0; i++) begin
         step(1);
         f = iwd ? iwd_fault_q : wwd_fault_q;
      end
   endtask : wait_f
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_actions();
      dwt_pkg::dwt_fault_s f;
      int unsigned         t0;
      for (int a = 0; a < 3; a++) begin
         do_reset(1'b0);
         cfg(1'b0, dwt_pkg::dwt_action_e'(a), 14'h0005, 14'h3fff, 14'h0000);
         step(1);
         cfg(1'b0, dwt_pkg::dwt_action_e'((a + 1) % 3), 14'h0005, 14'h3fff, 14'h0000);
         t0 = n_rst + n_nmi + n_irq;
         wait_f(1'b0, f);
         chk_f("wwd_fault", 3'h4 >> a, f);
         step(1);
         chk_b("ctl_tally", 1'b1, (n_rst + n_nmi + n_irq) == t0 + 1);
         step(20);
         chk_b("wwd_running", 1'b1, wwd_running_q);
      end
   endtask : test_actions
   task automatic test_window();
      do_reset(1'b0);
      refresh(1'b0);
      step(3);
      chk_b("wwd_refresh_err", 1'b0, wwd_refresh_err_q);
      cfg(1'b0, dwt_pkg::ACT_IRQ, 14'h0014, 14'h000a, 14'h0005);
      step(4);
      refresh(1'b0);
      step(3);
      chk_b("wwd_refresh_err", 1'b1, wwd_refresh_err_q);
      for (int i = 0; i < 40 && wwd_count_q !== 14'h0008; i++) step(1);
      refresh(1'b0);
      step(3);
      chk_b("wwd_refresh_err", 1'b0, wwd_refresh_err_q);
      chk_b("wwd_reload", 1'b1, wwd_count_q > 14'h000c);
   endtask : test_window
   task automatic test_iwd_err();
      dwt_pkg::dwt_fault_s f;
      do_reset(1'b1);
      // Count starts at the reset reload, above this window
      cfg(1'b1, dwt_pkg::ACT_IRQ, 14'h0006, 14'h3ffe, 14'h0005);
      refresh(1'b1);
      wait_f(1'b1, f);
      chk_f("iwd_fault", 3'h1, f);
      chk_b("iwd_refresh_err", 1'b1, iwd_refresh_err_q);
      chk_b("iwd_running", 1'b1, iwd_running_q);
      refresh(1'b1);
      step(2);
      chk_b("iwd_refresh_err", 1'b0, iwd_refresh_err_q);
   endtask : test_iwd_err
   task automatic test_iwd(input logic strap);
      dwt_pkg::dwt_fault_s f;
      do_reset(strap);
      step(2);
      chk_b("iwd_running", strap, iwd_running_q);
      cfg(1'b1, dwt_pkg::ACT_NMI, 14'h0003, 14'h3fff, 14'h0000);
      refresh(1'b1);
      step(4);
      chk_b("iwd_running", 1'b1, iwd_running_q);
      step(10);
      chk_b("iwd_hold", 1'b1, iwd_count_q == 14'h0003);
      osc_en = 1'b1;
      wait_f(1'b1, f);
      chk_f("iwd_fault", 3'h2, f);
      step(6);
      chk_b("iwd_running", strap, iwd_running_q);
   endtask : test_iwd
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   initial begin
      test_actions();
      test_window();
      test_iwd_err();
      test_iwd(1'b0);
      test_iwd(1'b1);
      finish_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #3000000;
      mismatches++;
      finish_test();
   end
endmodule : dwt_top_tb
